// File: logic/aircb_defs.svh
`ifndef AIRCB_DEFS_SVH
`define AIRCB_DEFS_SVH

// Register indices on the serial control port
`define AIRCB_ADDR_SOFT_RESET   7'h00
`define AIRCB_ADDR_MODE_DIVIDE  7'h31
`define AIRCB_ADDR_SEL_PAIR_A   7'h3a
`define AIRCB_ADDR_SEL_PAIR_B   7'h3b
`define AIRCB_ADDR_BIAS_CM      7'h50
`define AIRCB_ADDR_FS_TRIM      7'h55

// Field positions
`define AIRCB_SOFT_RESET_BIT    0
`define AIRCB_CHAN_LSB          0
`define AIRCB_DIV_LSB           8
`define AIRCB_SEL_LO_LSB        0
`define AIRCB_SEL_HI_LSB        8
`define AIRCB_BIAS_LSB          0
`define AIRCB_CM_LSB            4
`define AIRCB_TRIM_LSB          0

// Reset values
`define AIRCB_RST_DIV           2'h0
`define AIRCB_RST_CHAN          3'h4
`define AIRCB_RST_SEL_CORE1     5'h02
`define AIRCB_RST_SEL_CORE2     5'h04
`define AIRCB_RST_SEL_CORE3     5'h08
`define AIRCB_RST_SEL_CORE4     5'h10
`define AIRCB_RST_BIAS          3'h0
`define AIRCB_RST_CM            2'h1
`define AIRCB_RST_TRIM          6'h20

// Frame layout and timing
`define AIRCB_FRAME_BITS        5'd24
`define AIRCB_ADDR_BITS         5'd8
`define AIRCB_READ_FLAG_BIT     23
`define AIRCB_HALF_CYCLES       8
`define AIRCB_HALF_MIN          8

`endif

// File: logic/aircb_pkg.sv
package aircb_pkg;

   // One-hot crosspoint select, bit 0 always zero
   typedef logic [4:0] aircb_src_sel_t;

   // Host sequencer states
   typedef enum logic [4:0] {
      AIRCB_ST_IDLE = 5'b00001,
      AIRCB_ST_LOW  = 5'b00010,
      AIRCB_ST_HIGH = 5'b00100,
      AIRCB_ST_END  = 5'b01000,
      AIRCB_ST_GAP  = 5'b10000
   } aircb_host_state_t;

endpackage

// File: logic/aircb_ctrl_if.sv
`timescale 1ns/1ps
interface aircb_ctrl_if;
   logic sclk;
   logic sen_n;
   logic sdata;
   logic sdout;

   modport dev (
      input  sclk,
      input  sen_n,
      input  sdata,
      output sdout
   );

   modport host (
      output sclk,
      output sen_n,
      output sdata,
      input  sdout
   );
endinterface

// File: logic/aircb_device.sv
`timescale 1ns/1ps
`include "aircb_defs.svh"
// Function
// RL1: Divide input clock by 1, 2, 4, 8.
// RL2: Prescale code resets to divide by one.
// RL3: Software may match divisor to channel count.
// RL4: Five-bit one-hot source select per core.
// RL5: Cores default to inputs one to four.
// RL6: Core selects at bits 4:0, 12:8.
// RL7: Select changes apply when command ends.
// RL8: Six-bit full-scale trim, midcode means none.
// RL9: Higher trim code never gives less range.
// RL10: Bias code decode; codes 001-011 forbidden.
// RL11: Bias bits 2:0, buffer strength bits 5:4.
// RL12: Software may switch or raise buffer.
// RL13: Buffer code: off, low, medium, highest.
// RL14: Channel count must be exactly one-hot.
// RL15: Fields hold until rewritten; unused bits zero.
module aircb_device (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   // Serial control port
   aircb_ctrl_if.dev                  ctrl,
   // Clock prescaler
   output logic                       sample_strobe_o,
   output logic [1:0]                 clk_divide_code_o,
   output logic [2:0]                 channel_count_o,
   // Crosspoint selects
   output aircb_pkg::aircb_src_sel_t  core1_source_select_o,
   output aircb_pkg::aircb_src_sel_t  core2_source_select_o,
   output aircb_pkg::aircb_src_sel_t  core3_source_select_o,
   output aircb_pkg::aircb_src_sel_t  core4_source_select_o,
   // Analog trims
   output logic [5:0]                 full_scale_trim_code_o,
   output logic [2:0]                 core_bias_code_o,
   output logic [1:0]                 cm_buffer_strength_code_o,
   output logic                       cm_buffer_enable_o
);

   // Low-bit mask of the prescale divisor
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      unique case (code)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         2'h3:    div_mask = 3'h7;
      endcase
   endfunction

   // Pin synchronisers
   logic        sclk_s1_reg;
   logic        sclk_s2_reg;
   logic        sclk_d_reg;
   logic        sen_s1_reg;
   logic        sen_s2_reg;
   logic        sen_d_reg;
   logic        sdata_s1_reg;
   logic        sdata_s2_reg;

   // Frame capture
   logic [23:0] shift_reg;
   logic [4:0]  bit_cnt_reg;
   logic [15:0] rd_shift_reg;

   // Configuration fields
   logic [1:0]                 div_reg;
   logic [2:0]                 chan_reg;
   aircb_pkg::aircb_src_sel_t  sel1_reg;
   aircb_pkg::aircb_src_sel_t  sel2_reg;
   aircb_pkg::aircb_src_sel_t  sel3_reg;
   aircb_pkg::aircb_src_sel_t  sel4_reg;
   logic [2:0]                 bias_reg;
   logic [1:0]                 cm_reg;
   logic                       cm_en_reg;
   logic [5:0]                 trim_reg;

   // Prescaler
   logic [2:0]  div_cnt_reg;
   logic [2:0]  div_cnt_next;
   logic        strobe_reg;

   // No logic looks at the first stage; edge detects use the second and delayed stages
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_s1_reg  <= 1'b0;
         sclk_s2_reg  <= 1'b0;
         sclk_d_reg   <= 1'b0;
         sen_s1_reg   <= 1'b1;
         sen_s2_reg   <= 1'b1;
         sen_d_reg    <= 1'b1;
         sdata_s1_reg <= 1'b0;
         sdata_s2_reg <= 1'b0;
      end else begin
         sclk_s1_reg  <= ctrl.sclk;
         sclk_s2_reg  <= sclk_s1_reg;
         sclk_d_reg   <= sclk_s2_reg;
         sen_s1_reg   <= ctrl.sen_n;
         sen_s2_reg   <= sen_s1_reg;
         sen_d_reg    <= sen_s2_reg;
         sdata_s1_reg <= ctrl.sdata;
         sdata_s2_reg <= sdata_s1_reg;
      end
   end

   // Frame decode
   wire         sclk_rise   = sclk_s2_reg & ~sclk_d_reg & ~sen_s2_reg;
   wire         frame_end   = sen_s2_reg & ~sen_d_reg;
   wire [23:0]  shift_next  = {shift_reg[22:0], sdata_s2_reg};
   wire [6:0]   frame_addr  = shift_reg[22:16];
   wire [15:0]  frame_data  = shift_reg[15:0];
   wire         frame_write = frame_end & (bit_cnt_reg == `AIRCB_FRAME_BITS)
                              & ~shift_reg[`AIRCB_READ_FLAG_BIT];
   wire         addr_done   = sclk_rise & (bit_cnt_reg == `AIRCB_ADDR_BITS - 5'd1);
   wire         rd_request  = addr_done & shift_next[7];
   wire [6:0]   rd_addr     = shift_next[6:0];

   // Write strobes per register
   wire wr_soft  = frame_write & (frame_addr == `AIRCB_ADDR_SOFT_RESET)
                   & frame_data[`AIRCB_SOFT_RESET_BIT];
   wire wr_mode  = frame_write & (frame_addr == `AIRCB_ADDR_MODE_DIVIDE);
   wire wr_sel_a = frame_write & (frame_addr == `AIRCB_ADDR_SEL_PAIR_A);
   wire wr_sel_b = frame_write & (frame_addr == `AIRCB_ADDR_SEL_PAIR_B);
   wire wr_bias  = frame_write & (frame_addr == `AIRCB_ADDR_BIAS_CM);
   wire wr_trim  = frame_write & (frame_addr == `AIRCB_ADDR_FS_TRIM);

   // Readback words, unused positions zero
   wire [15:0] rd_mode  = {6'h00, div_reg, 5'h00, chan_reg};            // [RL15]
   wire [15:0] rd_sel_a = {3'h0, sel2_reg[4:1], 1'b0, 3'h0, sel1_reg[4:1], 1'b0}; // [RL4]
   wire [15:0] rd_sel_b = {3'h0, sel4_reg[4:1], 1'b0, 3'h0, sel3_reg[4:1], 1'b0}; // [RL6]
   wire [15:0] rd_bias  = {10'h000, cm_reg, 1'b0, bias_reg};            // [RL11]
   wire [15:0] rd_trim  = {10'h000, trim_reg};                          // [RL8]
   wire [15:0] rd_word  = (rd_addr == `AIRCB_ADDR_MODE_DIVIDE) ? rd_mode  :
                          (rd_addr == `AIRCB_ADDR_SEL_PAIR_A)  ? rd_sel_a :
                          (rd_addr == `AIRCB_ADDR_SEL_PAIR_B)  ? rd_sel_b :
                          (rd_addr == `AIRCB_ADDR_BIAS_CM)     ? rd_bias  :
                          (rd_addr == `AIRCB_ADDR_FS_TRIM)     ? rd_trim  : 16'h0000;

   // Bit counter saturates so an overlong frame is never taken
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_reg   <= 24'h000000;
         bit_cnt_reg <= 5'h00;
      end else if (sen_s2_reg) begin
         bit_cnt_reg <= frame_end ? bit_cnt_reg : 5'h00;
      end else if (sclk_rise) begin
         shift_reg   <= shift_next;
         bit_cnt_reg <= (bit_cnt_reg == 5'h1f) ? bit_cnt_reg : bit_cnt_reg + 5'h01;
      end
   end

   // Read data leaves msb first, one bit per clock rise
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_shift_reg <= 16'h0000;
      end else if (sen_s2_reg) begin
         rd_shift_reg <= 16'h0000;
      end else if (rd_request) begin
         rd_shift_reg <= rd_word;
      end else if (sclk_rise) begin
         rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
      end
   end

   // Mode and divider; applied only when the frame closes
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg  <= `AIRCB_RST_DIV;                                    // [RL2]
         chan_reg <= `AIRCB_RST_CHAN;
      end else if (wr_soft) begin
         div_reg  <= `AIRCB_RST_DIV;                                    // [RL2]
         chan_reg <= `AIRCB_RST_CHAN;
      end else if (wr_mode) begin
         div_reg  <= frame_data[`AIRCB_DIV_LSB +: 2];                   // [RL15]
         chan_reg <= frame_data[`AIRCB_CHAN_LSB +: 3];
      end
   end

   // Crosspoint; no power-down needed, bit 0 forced to zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sel1_reg <= `AIRCB_RST_SEL_CORE1;                              // [RL5]
         sel2_reg <= `AIRCB_RST_SEL_CORE2;
         sel3_reg <= `AIRCB_RST_SEL_CORE3;
         sel4_reg <= `AIRCB_RST_SEL_CORE4;
      end else if (wr_soft) begin
         sel1_reg <= `AIRCB_RST_SEL_CORE1;                              // [RL5]
         sel2_reg <= `AIRCB_RST_SEL_CORE2;
         sel3_reg <= `AIRCB_RST_SEL_CORE3;
         sel4_reg <= `AIRCB_RST_SEL_CORE4;
      end else begin
         if (wr_sel_a) begin                                            // [RL7]
            sel1_reg <= {frame_data[`AIRCB_SEL_LO_LSB + 1 +: 4], 1'b0}; // [RL6]
            sel2_reg <= {frame_data[`AIRCB_SEL_HI_LSB + 1 +: 4], 1'b0}; // [RL4]
         end
         if (wr_sel_b) begin                                            // [RL7]
            sel3_reg <= {frame_data[`AIRCB_SEL_LO_LSB + 1 +: 4], 1'b0}; // [RL6]
            sel4_reg <= {frame_data[`AIRCB_SEL_HI_LSB + 1 +: 4], 1'b0};
         end
      end
   end

   // Bias, buffer strength and full-scale trim
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bias_reg <= `AIRCB_RST_BIAS;                                   // [RL10]
         cm_reg   <= `AIRCB_RST_CM;                                     // [RL13]
         cm_en_reg <= |`AIRCB_RST_CM;
         trim_reg <= `AIRCB_RST_TRIM;                                   // [RL8]
      end else if (wr_soft) begin
         bias_reg <= `AIRCB_RST_BIAS;
         cm_reg   <= `AIRCB_RST_CM;
         cm_en_reg <= |`AIRCB_RST_CM;
         trim_reg <= `AIRCB_RST_TRIM;
      end else begin
         if (wr_bias) begin
            bias_reg <= frame_data[`AIRCB_BIAS_LSB +: 3];               // [RL11]
            cm_reg   <= frame_data[`AIRCB_CM_LSB +: 2];                 // [RL11]
            // Enable kept in its own flop so the pin has no gate after it
            cm_en_reg <= |frame_data[`AIRCB_CM_LSB +: 2];               // [RL13]
         end
         if (wr_trim) begin
            trim_reg <= frame_data[`AIRCB_TRIM_LSB +: 6];               // [RL8]
         end
      end
   end

   // Strobe one cycle in every 1, 2, 4 or 8
   assign div_cnt_next = div_cnt_reg + 3'h1;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_cnt_reg <= 3'h0;
         strobe_reg  <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         strobe_reg  <= (div_cnt_next & div_mask(div_reg)) == 3'h0;     // [RL1]
      end
   end

   // Outputs straight from flops; trim code is plain binary, so monotonic
   assign sample_strobe_o           = strobe_reg;
   assign clk_divide_code_o         = div_reg;
   assign channel_count_o           = chan_reg;
   assign core1_source_select_o     = sel1_reg;
   assign core2_source_select_o     = sel2_reg;
   assign core3_source_select_o     = sel3_reg;
   assign core4_source_select_o     = sel4_reg;
   assign full_scale_trim_code_o    = trim_reg;                         // [RL9]
   assign core_bias_code_o          = bias_reg;
   assign cm_buffer_strength_code_o = cm_reg;
   assign cm_buffer_enable_o        = cm_en_reg;                        // [RL13]
   assign ctrl.sdout                = rd_shift_reg[15];

endmodule

// File: logic/aircb_host.sv
`timescale 1ns/1ps
`include "aircb_defs.svh"
module aircb_host #(
   parameter int HALF_CYCLES = `AIRCB_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Serial control port
   aircb_ctrl_if.host        ctrl,
   // Command request
   input  wire logic         cmd_valid_i,
   input  wire logic         cmd_read_i,
   input  wire logic [6:0]   cmd_addr_i,
   input  wire logic [15:0]  cmd_wdata_i,
   output logic              cmd_ready_o,
   // Command answer
   output logic              rsp_valid_o,
   output logic              rsp_error_o,
   output logic [15:0]       rsp_rdata_o
);

   // Phases shorter than the device's synchroniser latency would lose bits
   if (HALF_CYCLES < `AIRCB_HALF_MIN || HALF_CYCLES > 255) begin : g_half_check
      $error("aircb_host: HALF_CYCLES out of range");
   end

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

   // Legal one-hot crosspoint code
   function automatic logic sel_ok(input logic [4:0] code);
      sel_ok = (code == 5'h02) | (code == 5'h04) | (code == 5'h08) | (code == 5'h10);
   endfunction

   // Refuse writes carrying forbidden codes
   wire [15:0] wd       = cmd_wdata_i;
   wire        bad_sel  = ((cmd_addr_i == `AIRCB_ADDR_SEL_PAIR_A) |
                           (cmd_addr_i == `AIRCB_ADDR_SEL_PAIR_B)) &
                          ~(sel_ok(wd[`AIRCB_SEL_LO_LSB +: 5]) &
                            sel_ok(wd[`AIRCB_SEL_HI_LSB +: 5]));                  // [RL4]
   wire [2:0]  bias_f   = wd[`AIRCB_BIAS_LSB +: 3];
   wire        bad_bias = (cmd_addr_i == `AIRCB_ADDR_BIAS_CM) &
                          ~bias_f[2] & (bias_f != 3'h0);                          // [RL10]
   wire [2:0]  chan_f   = wd[`AIRCB_CHAN_LSB +: 3];
   wire        bad_chan = (cmd_addr_i == `AIRCB_ADDR_MODE_DIVIDE) &
                          ~((chan_f == 3'h1) | (chan_f == 3'h2) | (chan_f == 3'h4)); // [RL14]
   wire        refuse   = ~cmd_read_i & (bad_sel | bad_bias | bad_chan);

   aircb_pkg::aircb_host_state_t state_reg;
   logic [23:0] shift_reg;
   logic [4:0]  bit_cnt_reg;
   logic [7:0]  half_cnt_reg;
   logic        sclk_reg;
   logic        sen_n_reg;
   logic        ready_reg;
   logic        rsp_reg;
   logic        err_reg;
   logic [15:0] rdata_reg;
   logic        sdout_s1_reg;
   logic        sdout_s2_reg;

   wire half_done = (half_cnt_reg == HALF_LAST);
   wire take      = cmd_valid_i & ready_reg;
   wire rd_window = (bit_cnt_reg >= `AIRCB_ADDR_BITS - 5'd1) &
                    (bit_cnt_reg <= `AIRCB_FRAME_BITS - 5'd2);

   // Read line synchroniser
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sdout_s1_reg <= 1'b0;
         sdout_s2_reg <= 1'b0;
      end else begin
         sdout_s1_reg <= ctrl.sdout;
         sdout_s2_reg <= sdout_s1_reg;
      end
   end

   // Frame sequencer; gap state keeps enable high long enough to be seen
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg    <= aircb_pkg::AIRCB_ST_IDLE;
         shift_reg    <= 24'h000000;
         bit_cnt_reg  <= 5'h00;
         half_cnt_reg <= 8'h00;
         sclk_reg     <= 1'b0;
         sen_n_reg    <= 1'b1;
         ready_reg    <= 1'b1;
         rsp_reg      <= 1'b0;
         err_reg      <= 1'b0;
         rdata_reg    <= 16'h0000;
      end else begin
         rsp_reg      <= 1'b0;
         err_reg      <= 1'b0;
         half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
         unique case (state_reg)
            aircb_pkg::AIRCB_ST_IDLE: begin
               half_cnt_reg <= 8'h00;
               if (take && refuse) begin
                  rsp_reg <= 1'b1;
                  err_reg <= 1'b1;
               end else if (take) begin
                  ready_reg   <= 1'b0;
                  shift_reg   <= {cmd_read_i, cmd_addr_i, cmd_wdata_i};
                  bit_cnt_reg <= 5'h00;
                  sen_n_reg   <= 1'b0;
                  state_reg   <= aircb_pkg::AIRCB_ST_LOW;
               end
            end
            aircb_pkg::AIRCB_ST_LOW: begin
               if (half_done) begin
                  sclk_reg  <= 1'b1;
                  state_reg <= aircb_pkg::AIRCB_ST_HIGH;
               end
            end
            aircb_pkg::AIRCB_ST_HIGH: begin
               if (half_done) begin
                  sclk_reg <= 1'b0;
                  if (rd_window) begin
                     rdata_reg <= {rdata_reg[14:0], sdout_s2_reg};
                  end
                  if (bit_cnt_reg == `AIRCB_FRAME_BITS - 5'd1) begin
                     state_reg <= aircb_pkg::AIRCB_ST_END;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     shift_reg   <= {shift_reg[22:0], 1'b0};
                     state_reg   <= aircb_pkg::AIRCB_ST_LOW;
                  end
               end
            end
            aircb_pkg::AIRCB_ST_END: begin
               if (half_done) begin
                  sen_n_reg <= 1'b1;
                  rsp_reg   <= 1'b1;
                  state_reg <= aircb_pkg::AIRCB_ST_GAP;
               end
            end
            aircb_pkg::AIRCB_ST_GAP: begin
               if (half_done) begin
                  ready_reg <= 1'b1;
                  state_reg <= aircb_pkg::AIRCB_ST_IDLE;
               end
            end
            default: begin
               state_reg <= aircb_pkg::AIRCB_ST_IDLE;
            end
         endcase
      end
   end

   assign ctrl.sclk   = sclk_reg;
   assign ctrl.sen_n  = sen_n_reg;
   assign ctrl.sdata  = shift_reg[23];
   assign cmd_ready_o = ready_reg;
   assign rsp_valid_o = rsp_reg;
   assign rsp_error_o = err_reg;
   assign rsp_rdata_o = rdata_reg;

endmodule

// File: tb/aircb_asserts.sv
`timescale 1ns/1ps
module aircb_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Serial link
   input wire logic sclk,
   input wire logic sen_n,
   input wire logic sdata,
   input wire logic sdout
);
   logic [4:0] rise_cnt_reg;
   logic [4:0] rise_cnt_next;
   logic       sclk_q_reg;
   wire        sclk_rise = sclk & ~sclk_q_reg;

   // Rising serial edges seen in the open frame; cleared while idle
   assign rise_cnt_next = sen_n ? 5'h00 : rise_cnt_reg + {4'h0, sclk_rise};

   // Counter flops, short on purpose
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rise_cnt_reg <= 5'h00;
         sclk_q_reg   <= 1'b0;
      end else begin
         rise_cnt_reg <= rise_cnt_next;
         sclk_q_reg   <= sclk;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Link timing, assumes the bench builds the host with eight-cycle phases
   AST_SCLK_IDLE: assert property (sen_n |-> !sclk)
      else $error("serial clock high outside a frame");
   AST_FRAME_START: assert property ($fell(sen_n) |-> !sclk [*8] ##1 sclk)
      else $error("first serial edge not eight cycles after frame start");
   AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("serial clock high phase not eight cycles");
   AST_LOW_PHASE: assert property ($fell(sclk) |-> !sclk [*8] ##1 (sclk || sen_n))
      else $error("serial clock low phase not eight cycles");
   AST_DATA_HOLD: assert property (sclk |-> $stable(sdata))
      else $error("host data moved while serial clock high");
   AST_FRAME_BITS: assert property ($rose(sen_n) |-> rise_cnt_reg == 5'h18)
      else $error("frame did not carry 24 bits");
   AST_FRAME_GAP: assert property ($rose(sen_n) |-> sen_n [*3])
      else $error("frames closer than three cycles");
   AST_SDOUT_QUIET: assert property (sen_n [*5] |-> !sdout)
      else $error("device drives read data outside a frame");
endmodule

// File: tb/aircb_tb.sv
`timescale 1ns/1ps
module aircb_tb;
   logic        clk_i       = 1'b0;
   logic        reset_i     = 1'b1;
   logic        cmd_valid_i = 1'b0;
   logic        cmd_read_i  = 1'b0;
   logic [6:0]  cmd_addr_i  = 7'h00;
   logic [15:0] cmd_wdata_i = 16'h0000;
   logic        cmd_ready_o, rsp_valid_o, rsp_error_o, strobe, cm_en;
   logic [15:0] rsp_rdata_o, rd_val, e12, e34;
   logic [1:0]  div_o, cm_o;
   logic [2:0]  chan_o, bias_o;
   logic [5:0]  trim_o;
   logic [4:0]  sel_end, s1, s2, prev;
   logic        err_val;
   aircb_pkg::aircb_src_sel_t c1, c2, c3, c4;
   logic [15:0] trim_w [4] = '{16'h003f, 16'h0000, 16'h0021, 16'hffff};
   logic [2:0]  bias_w [5] = '{3'h0, 3'h7, 3'h6, 3'h5, 3'h4};
   int          n_fail = 0;
   int          num_checks = 0;
   int          c;

   // 10 MHz clock
   always #50 clk_i = ~clk_i;

   aircb_ctrl_if i_aircb_ctrl_if ();
   aircb_device i_aircb_device (.clk_i(clk_i), .reset_i(reset_i), .ctrl(i_aircb_ctrl_if),
      .sample_strobe_o(strobe), .clk_divide_code_o(div_o), .channel_count_o(chan_o),
      .core1_source_select_o(c1), .core2_source_select_o(c2), .core3_source_select_o(c3),
      .core4_source_select_o(c4), .full_scale_trim_code_o(trim_o), .core_bias_code_o(bias_o),
      .cm_buffer_strength_code_o(cm_o), .cm_buffer_enable_o(cm_en));
   aircb_host #(.HALF_CYCLES(8)) i_aircb_host (.clk_i(clk_i), .reset_i(reset_i),
      .ctrl(i_aircb_ctrl_if), .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o), .rsp_rdata_o(rsp_rdata_o));
   aircb_asserts i_aircb_asserts (.clk_i(clk_i), .reset_i(reset_i),
      .sclk(i_aircb_ctrl_if.sclk), .sen_n(i_aircb_ctrl_if.sen_n),
      .sdata(i_aircb_ctrl_if.sdata), .sdout(i_aircb_ctrl_if.sdout));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Inputs move 1 ns after the edge so no race with the design
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // One command; read data and the old core 1 select captured at the end pulse
   task automatic cmd(input logic rd, input logic [6:0] a, input logic [15:0] d);
      int i;
      i = 0;
      while (cmd_ready_o !== 1'b1 && i < 2000) begin
         tick(1);
         i++;
      end
      cmd_valid_i = 1'b1;
      cmd_read_i  = rd;
      cmd_addr_i  = a;
      cmd_wdata_i = d;
      tick(1);
      cmd_valid_i = 1'b0;
      while (rsp_valid_o !== 1'b1 && i < 2000) begin
         tick(1);
         i++;
      end
      if (i >= 2000) begin
         n_fail++;
         stop_test();
      end
      err_val = rsp_error_o;
      rd_val  = rsp_rdata_o;
      sel_end = c1;
      tick(6);
   endtask

   task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
      cmd(1'b1, a, 16'h0000);
      chk("readback", exp, rd_val);
   endtask

   task automatic chk_defaults;
      chk("divide", 16'h0000, {14'h0, div_o});
      chk("channel", 16'h0004, {13'h0, chan_o});
      chk("cores12", 16'h0402, {3'h0, c2, 3'h0, c1});
      chk("cores34", 16'h1008, {3'h0, c4, 3'h0, c3});
      chk("trim", 16'h0020, {10'h0, trim_o});
      chk("bias_cm", 16'h0010, {10'h0, cm_o, 1'b0, bias_o});
   endtask

   initial begin
      tick(20);
      reset_i = 1'b0;
      chk_defaults();
      chk("cm_en", 16'h0001, {15'h0, cm_en});
      rchk(7'h3a, 16'h0402);
      rchk(7'h3b, 16'h1008);
      rchk(7'h50, 16'h0010);
      rchk(7'h55, 16'h0020);
      rchk(7'h7f, 16'h0000);
      // Divider tracks channel count; strobes counted over 64 cycles
      for (int d = 0; d < 4; d++) begin
         cmd(1'b0, 7'h31, {6'h0, 2'(d), 5'h0, (d == 0) ? 3'h1 : (d == 1) ? 3'h2 : 3'h4});
         chk("divide", 16'(d), {14'h0, div_o});
         chk("channel", (d == 0) ? 16'h1 : (d == 1) ? 16'h2 : 16'h4, {13'h0, chan_o});
         c = 0;
         repeat (64) begin
            tick(1);
            if (strobe === 1'b1) c++;
         end
         chk("strobes", 16'(64 >> d), 16'(c));
      end
      // Rotate every core through all four inputs
      for (int i = 0; i < 4; i++) begin
         s1   = 5'(5'h02 << i);
         s2   = 5'(5'h02 << ((i + 1) % 4));
         prev = c1;
         e12  = {3'h0, s2, 3'h0, s1};
         e34  = {3'h0, s1, 3'h0, s2};
         cmd(1'b0, 7'h3a, e12);
         chk("sel_at_end", {11'h0, prev}, {11'h0, sel_end});
         chk("err", 16'h0000, {15'h0, err_val});
         chk("cores12", e12, {3'h0, c2, 3'h0, c1});
         cmd(1'b0, 7'h3b, e34);
         chk("cores34", e34, {3'h0, c4, 3'h0, c3});
         rchk(7'h3b, e34);
      end
      // Non one-hot select must be turned away, selects untouched
      cmd(1'b0, 7'h3a, 16'h0406);
      chk("err", 16'h0001, {15'h0, err_val});
      chk("cores12", e12, {3'h0, c2, 3'h0, c1});
      // Trim extremes; upper bits written as ones read back zero
      foreach (trim_w[k]) begin
         cmd(1'b0, 7'h55, trim_w[k]);
         chk("trim", {10'h0, trim_w[k][5:0]}, {10'h0, trim_o});
         rchk(7'h55, {10'h0, trim_w[k][5:0]});
      end
      // Every legal bias code, buffer strength cycled including off
      foreach (bias_w[k]) begin
         cmd(1'b0, 7'h50, {10'h0, 2'(k), 1'b0, bias_w[k]});
         chk("bias_cm", {10'h0, 2'(k), 1'b0, bias_w[k]}, {10'h0, cm_o, 1'b0, bias_o});
         chk("cm_en", {15'h0, (k % 4) != 0}, {15'h0, cm_en});
      end
      cmd(1'b0, 7'h50, 16'h0011);
      chk("err", 16'h0001, {15'h0, err_val});
      chk("bias_cm", 16'h0004, {10'h0, cm_o, 1'b0, bias_o});
      // Software reset restores every field and clears itself
      cmd(1'b0, 7'h00, 16'h0001);
      chk_defaults();
      rchk(7'h00, 16'h0000);
      stop_test();
   end
endmodule
